// ### epem_pkg.sv
// Package for the external pin event monitor: widths, codes, reset values, timing.
// Assumes a 20 MHz system clock.
`default_nettype none
package epem_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int EPEM_EVENTS    = 16;
  localparam int EPEM_SEL_W     = 4;
  localparam int EPEM_THR_W     = 12;
  // ----------------------------------------
  // Threshold scale: code full scale is 3.3 V
  // ----------------------------------------
  localparam logic [11:0] EPEM_THR_MAX     = 12'hfff;  // 3.3 V
  localparam logic [11:0] EPEM_THR_DEFAULT = 12'h800;  // 1.65 V
  // ----------------------------------------
  // Direction and force codes
  // ----------------------------------------
  localparam logic EPEM_DIR_IN  = 1'b0;
  localparam logic EPEM_DIR_OUT = 1'b1;
  localparam logic [1:0] EPEM_FORCE_EVENT = 2'h3;  // -1 in two bits
  localparam logic [1:0] EPEM_FORCE_LOW   = 2'h0;
  localparam logic [1:0] EPEM_FORCE_HIGH  = 2'h1;
  // ----------------------------------------
  // Reset values and defined-event mask
  // ----------------------------------------
  localparam logic [15:0] EPEM_MASK_RESET  = 16'h0000;
  localparam logic        EPEM_DIR_RESET   = 1'b0;
  localparam logic [1:0]  EPEM_FORCE_RESET = 2'h3;
  localparam logic [15:0] EPEM_DEFINED     = 16'h07ff;  // events 0..10
  // ----------------------------------------
  // Sampling interval
  // ----------------------------------------
  localparam int EPEM_CLK_HZ       = 20000000;
  localparam int EPEM_SAMPLE_NS    = 1000;
  localparam int EPEM_SAMPLE_CYC   = (EPEM_SAMPLE_NS * (EPEM_CLK_HZ / 1000000)) / 1000;
  localparam logic [4:0] EPEM_SAMPLE_LAST = 5'(EPEM_SAMPLE_CYC - 1);

  typedef enum logic [2:0] {
    EPEM_S_IDLE  = 3'b001,
    EPEM_S_WAIT  = 3'b010,
    EPEM_S_TAKE  = 3'b100
  } epem_samp_t;
endpackage
`default_nettype wire

// ### epem_sync.sv
// Two-flop synchroniser bank for event and comparator inputs.
// Assumes inputs are asynchronous to clk; reset is already synchronised.
`default_nettype none
module epem_sync
  import epem_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rstN,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);
  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_dout;

  always_comb begin
    next_stage1 = din;
    next_dout   = stage1;
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      stage1 <= '0;
      dout   <= '0;
    end else begin
      stage1 <= next_stage1;
      dout   <= next_dout;
    end
  end
endmodule // epem_sync
`default_nettype wire

// ### epem_monitor.sv
// External pin event monitor: one back-panel pin, pin and relay event masks.
// Assumes a 20 MHz clk, async active-low rst_n, host commands as one-cycle strobes.
`default_nettype none
module epem_monitor
  import epem_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Configuration strobes
  input  wire logic        dirWrite,
  input  wire logic        dirValue,
  input  wire logic        thrWrite,
  input  wire logic        thrDefault,
  input  wire logic [11:0] thrValue,
  input  wire logic        forceWrite,
  input  wire logic [1:0]  forceValue,
  input  wire logic        pinEvtBitWrite,
  input  wire logic        relayEvtBitWrite,
  input  wire logic [3:0]  evtSel,
  input  wire logic        evtBitValue,
  input  wire logic        pinMaskWrite,
  input  wire logic        relayMaskWrite,
  input  wire logic [15:0] maskValue,
  // Live inputs
  input  wire logic [15:0] eventIn,
  input  wire logic        pinAboveThr,
  input  wire logic        pinConnected,
  // Readback
  output var  logic        dirRead,
  output var  logic [11:0] thrRead,
  output var  logic [1:0]  forceRead,
  output var  logic        levelRead,
  output var  logic        pinEvtEnRead,
  output var  logic [15:0] pinMaskRead,
  output var  logic [15:0] relayMaskRead,
  output var  logic        pinCondRead,
  output var  logic [15:0] pinCondMaskRead,
  // Pin and relay
  output var  logic [11:0] thrDac,
  output var  logic        pinOut,
  output var  logic        pinOe,
  output var  logic        relayOn
);
  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rstMeta;
  logic rstN;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta <= 1'b0;
      rstN    <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstN    <= rstMeta;
    end
  end

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [17:0] syncIn;
  logic [15:0] evtSync;
  logic        aboveSync;
  logic        connSync;
  epem_sync #(.W(18)) u_sync (
    .clk  (clk),
    .rstN (rstN),
    .din  ({pinConnected, pinAboveThr, eventIn}),
    .dout (syncIn)
  );
  assign evtSync   = syncIn[15:0] & EPEM_DEFINED;
  assign aboveSync = syncIn[16];
  assign connSync  = syncIn[17];

  function automatic logic [15:0] bitUpdate(input logic [15:0] m, input logic [3:0] s,
                                            input logic v);
    logic [15:0] r;
    r    = m;
    r[s] = v;
    return r;
  endfunction

  // ----------------------------------------
  // Configuration state
  // ----------------------------------------
  logic        dir;
  logic [11:0] thr;
  logic [1:0]  force_;
  logic [15:0] pinMask;
  logic [15:0] relayMask;
  logic        next_dir;
  logic [11:0] next_thr;
  logic [1:0]  next_force;
  logic [15:0] next_pinMask;
  logic [15:0] next_relayMask;

  always_comb begin
    next_dir       = dir;
    next_thr       = thr;
    next_force     = force_;
    next_pinMask   = pinMask;
    next_relayMask = relayMask;
    if (dirWrite) begin
      next_dir = dirValue;
    end
    if (thrDefault) begin
      next_thr = EPEM_THR_DEFAULT;
    end else if (thrWrite) begin
      next_thr = (thrValue > EPEM_THR_MAX) ? EPEM_THR_MAX : thrValue;
    end
    if (forceWrite && forceValue != 2'h2) begin
      next_force = forceValue;
    end
    if (pinMaskWrite) begin
      next_pinMask = maskValue;
    end else if (pinEvtBitWrite) begin
      next_pinMask = bitUpdate(pinMask, evtSel, evtBitValue);
    end
    if (relayMaskWrite) begin
      next_relayMask = maskValue;
    end else if (relayEvtBitWrite) begin
      next_relayMask = bitUpdate(relayMask, evtSel, evtBitValue);
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      dir       <= EPEM_DIR_RESET;
      thr       <= EPEM_THR_DEFAULT;
      force_    <= EPEM_FORCE_RESET;
      pinMask   <= EPEM_MASK_RESET;
      relayMask <= EPEM_MASK_RESET;
    end else begin
      dir       <= next_dir;
      thr       <= next_thr;
      force_    <= next_force;
      pinMask   <= next_pinMask;
      relayMask <= next_relayMask;
    end
  end

  // ----------------------------------------
  // Periodic level sampling
  // ----------------------------------------
  // Sampling only every interval filters fast comparator chatter.
  epem_samp_t  state;
  epem_samp_t  next_state;
  logic [4:0]  sampCnt;
  logic [4:0]  next_sampCnt;
  logic        level;
  logic        next_level;

  always_comb begin
    next_state   = state;
    next_sampCnt = sampCnt;
    next_level   = level;
    case (state)
      EPEM_S_IDLE: begin
        next_sampCnt = '0;
        next_state   = EPEM_S_WAIT;
      end
      EPEM_S_WAIT: begin
        next_sampCnt = sampCnt + 5'h01;
        if (sampCnt == EPEM_SAMPLE_LAST) begin
          next_state = EPEM_S_TAKE;
        end
      end
      EPEM_S_TAKE: begin
        next_level   = !connSync ? 1'b1 : aboveSync;
        next_sampCnt = '0;
        next_state   = EPEM_S_WAIT;
      end
      default: begin
        next_state = EPEM_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state   <= EPEM_S_IDLE;
      sampCnt <= '0;
      level   <= 1'b1;
    end else begin
      state   <= next_state;
      sampCnt <= next_sampCnt;
      level   <= next_level;
    end
  end

  // ----------------------------------------
  // Event outputs and readback
  // ----------------------------------------
  logic [15:0] pinCond;
  logic        pinEvtOut;
  logic        pinDrive;
  assign pinCond   = pinMask & evtSync;
  assign pinEvtOut = |pinCond;

  always_comb begin
    case (force_)
      EPEM_FORCE_LOW:  pinDrive = 1'b0;
      EPEM_FORCE_HIGH: pinDrive = 1'b1;
      default:         pinDrive = pinEvtOut;
    endcase
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pinOut          <= 1'b0;
      pinOe           <= 1'b0;
      relayOn         <= 1'b0;
      dirRead         <= 1'b0;
      thrRead         <= '0;
      thrDac          <= '0;
      forceRead       <= '0;
      levelRead       <= 1'b0;
      pinEvtEnRead    <= 1'b0;
      pinMaskRead     <= '0;
      relayMaskRead   <= '0;
      pinCondRead     <= 1'b0;
      pinCondMaskRead <= '0;
    end else begin
      pinOut          <= (dir == EPEM_DIR_OUT) && pinDrive;
      pinOe           <= (dir == EPEM_DIR_OUT);
      relayOn         <= |(relayMask & evtSync);
      dirRead         <= dir;
      thrRead         <= thr;
      thrDac          <= thr;
      forceRead       <= force_;
      levelRead       <= (dir == EPEM_DIR_IN) ? level : pinDrive;
      pinEvtEnRead    <= pinMask[evtSel];
      pinMaskRead     <= pinMask;
      relayMaskRead   <= relayMask;
      pinCondRead     <= pinCond[evtSel];
      pinCondMaskRead <= pinCond;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_DIR_OE: assert property (@(posedge clk) disable iff (!rstN)
    dirWrite |=> ##1 (pinOe == $past(dirValue, 2)))
    else $error("Pin enable does not follow direction write");
  AST_DIR_READ: assert property (@(posedge clk) disable iff (!rstN)
    ##1 (dirRead == $past(dir)))
    else $error("Direction readback wrong");
  AST_THR_DEF: assert property (@(posedge clk) disable iff (!rstN)
    thrDefault |=> (thr == EPEM_THR_DEFAULT))
    else $error("Default threshold not loaded");
  AST_LEVEL_OPEN: assert property (@(posedge clk) disable iff (!rstN)
    (state == EPEM_S_TAKE && !connSync) |=> level)
    else $error("Open input not read high");
  AST_LEVEL_SAMPLE: assert property (@(posedge clk) disable iff (!rstN)
    (state == EPEM_S_TAKE && connSync) |=> (level == $past(aboveSync)))
    else $error("Sampled level does not match comparator");
  AST_LEVEL_READ: assert property (@(posedge clk) disable iff (!rstN)
    (rstN && dir == EPEM_DIR_IN && !dirWrite) |=> (levelRead == $past(level)))
    else $error("Input level readback wrong");
  AST_PIN_EVENT: assert property (@(posedge clk) disable iff (!rstN)
    (dir && force_ == EPEM_FORCE_EVENT && |(pinMask & evtSync)) |=> pinOut)
    else $error("Enabled event did not raise pin");
  AST_RELAY_CLEAR: assert property (@(posedge clk) disable iff (!rstN)
    (relayMask & evtSync) == 16'h0000 |=> !relayOn)
    else $error("Relay did not drop without events");
  AST_BIT_WRITE: assert property (@(posedge clk) disable iff (!rstN)
    (pinEvtBitWrite && !pinMaskWrite) |=>
      (pinMask[$past(evtSel)] == $past(evtBitValue)))
    else $error("Single event write failed");
  AST_MASK_WRITE: assert property (@(posedge clk) disable iff (!rstN)
    relayMaskWrite |=> (relayMask == $past(maskValue)))
    else $error("Whole mask write failed");
  AST_RESERVED: assert property (@(posedge clk) disable iff (!rstN)
    (pinCond[15:11] == 5'h00))
    else $error("Reserved event became active");
  AST_COND: assert property (@(posedge clk) disable iff (!rstN)
    !pinMask[evtSel] |=> !pinCondRead)
    else $error("Disabled event reports condition");
endmodule // epem_monitor
`default_nettype wire

// ### epem_ext_model.sv
// Model of the external equipment on the back-panel pin, with its pull-up.
// Assumes the bench sets the applied voltage code and whether a wire is attached.
`default_nettype none
module epem_ext_model
  import epem_pkg::*;
(
  input  wire logic [11:0] extVolt,
  input  wire logic        extWired,
  input  wire logic [11:0] thrDac,
  input  wire logic        pinOut,
  input  wire logic        pinOe,
  output var  logic        pinAboveThr,
  output var  logic        pinConnected,
  output var  logic [11:0] pinVolt
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Pin voltage and comparator
  // ----------------------------------------
  always_comb begin
    if (pinOe) begin
      pinVolt = pinOut ? EPEM_THR_MAX : 12'h000;
    end else if (!extWired) begin
      pinVolt = EPEM_THR_MAX;
    end else begin
      pinVolt = extVolt;
    end
  end
  // Equal voltages read as not above the threshold
  assign pinAboveThr  = (pinVolt > thrDac);
  assign pinConnected = extWired | pinOe;
endmodule  // epem_ext_model
`default_nettype wire

// ### epem_monitor_bench.sv
// Self-checking bench for the external pin event monitor.
// Assumes the model stands at the pin; host commands are one-cycle strobes.
`default_nettype none
module epem_monitor_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import epem_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk = 1'b0, rst_n = 1'b0, dirWrite = 1'b0, dirValue = 1'b0, thrWrite = 1'b0;
  logic thrDefault = 1'b0, forceWrite = 1'b0, pinEvtBitWrite = 1'b0, relayEvtBitWrite = 1'b0;
  logic evtBitValue = 1'b0, pinMaskWrite = 1'b0, relayMaskWrite = 1'b0, extWired = 1'b0;
  logic [11:0] thrValue = 12'h000, extVolt = 12'h000;
  logic [1:0]  forceValue = 2'h0;
  logic [3:0]  evtSel = 4'h0;
  logic [15:0] maskValue = 16'h0000, eventIn = 16'h0000;
  logic pinAboveThr, pinConnected, dirRead, levelRead, pinEvtEnRead, pinCondRead;
  logic pinOut, pinOe, relayOn;
  logic [11:0] thrRead, thrDac, pinVolt;
  logic [1:0]  forceRead;
  logic [15:0] pinMaskRead, relayMaskRead, pinCondMaskRead;
  int num_errors = 0;
  int n_tests = 0;
  always #25 clk = ~clk;
  // ----------------------------------------
  // Design and partner
  // ----------------------------------------
  epem_monitor i_dut (.clk(clk), .rst_n(rst_n), .dirWrite(dirWrite), .dirValue(dirValue),
    .thrWrite(thrWrite), .thrDefault(thrDefault), .thrValue(thrValue),
    .forceWrite(forceWrite), .forceValue(forceValue), .pinEvtBitWrite(pinEvtBitWrite),
    .relayEvtBitWrite(relayEvtBitWrite), .evtSel(evtSel), .evtBitValue(evtBitValue),
    .pinMaskWrite(pinMaskWrite), .relayMaskWrite(relayMaskWrite), .maskValue(maskValue),
    .eventIn(eventIn), .pinAboveThr(pinAboveThr), .pinConnected(pinConnected),
    .dirRead(dirRead), .thrRead(thrRead), .forceRead(forceRead), .levelRead(levelRead),
    .pinEvtEnRead(pinEvtEnRead), .pinMaskRead(pinMaskRead), .relayMaskRead(relayMaskRead),
    .pinCondRead(pinCondRead), .pinCondMaskRead(pinCondMaskRead), .thrDac(thrDac),
    .pinOut(pinOut), .pinOe(pinOe), .relayOn(relayOn));
  epem_ext_model i_ext (.extVolt(extVolt), .extWired(extWired), .thrDac(thrDac),
    .pinOut(pinOut), .pinOe(pinOe), .pinAboveThr(pinAboveThr),
    .pinConnected(pinConnected), .pinVolt(pinVolt));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Clears every strobe, then lets the readback settle two edges later
  task automatic settle();
    @(posedge clk);
    {dirWrite, thrWrite, thrDefault, forceWrite} <= 4'h0;
    {pinEvtBitWrite, relayEvtBitWrite, pinMaskWrite, relayMaskWrite} <= 4'h0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic setDir(input logic v);
    @(posedge clk); dirWrite <= 1'b1; dirValue <= v; settle();
  endtask
  task automatic setForce(input logic [1:0] v);
    @(posedge clk); forceWrite <= 1'b1; forceValue <= v; settle();
  endtask
  task automatic setMask(input logic relay, input logic [15:0] v);
    @(posedge clk); pinMaskWrite <= !relay; relayMaskWrite <= relay; maskValue <= v; settle();
  endtask
  task automatic setBit(input logic relay, input logic [3:0] s, input logic v);
    @(posedge clk); pinEvtBitWrite <= !relay; relayEvtBitWrite <= relay;
    evtSel <= s; evtBitValue <= v; settle();
  endtask
  // Two sample intervals plus synchroniser delay
  task automatic waitSamples();
    repeat (50) @(posedge clk);
    #1;
  endtask
  task automatic setEvents(input logic [15:0] v);
    @(posedge clk); eventIn <= v; repeat (4) @(posedge clk); #1;
  endtask
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    waitSamples();
    chk(dirRead, EPEM_DIR_IN);
    chk(pinMaskRead, 16'h0000);
    chk(relayMaskRead, 16'h0000);
    chk(thrRead, EPEM_THR_DEFAULT);
    chk(levelRead, 1'b1);
    $display("t_reset done");
  endtask
  task automatic t_dir();
    setDir(1'b1);
    chk({dirRead, pinOe}, 2'h3);
    setDir(1'b0);
    chk({dirRead, pinOe}, 2'h0);
    $display("t_dir done");
  endtask
  task automatic t_thr();
    @(posedge clk); thrWrite <= 1'b1; thrValue <= 12'h400; settle();
    chk({thrRead, thrDac}, 24'h400400);
    extWired <= 1'b1; extVolt <= 12'h3ff; waitSamples();
    chk(levelRead, 1'b0);
    extVolt <= 12'h401; waitSamples();
    chk(levelRead, 1'b1);
    extVolt <= 12'h000; waitSamples();
    chk(levelRead, 1'b0);
    extWired <= 1'b0; waitSamples();
    chk(levelRead, 1'b1);
    @(posedge clk); thrDefault <= 1'b1; thrWrite <= 1'b1; thrValue <= 12'h123; settle();
    chk(thrRead, EPEM_THR_DEFAULT);
    $display("t_thr done");
  endtask
  task automatic t_mask();
    setMask(1'b0, 16'h0183);
    chk(pinMaskRead, 16'h0183);
    setBit(1'b0, 4'ha, 1'b1);
    setBit(1'b0, 4'h0, 1'b0);
    chk(pinMaskRead, 16'h0582);
    setBit(1'b0, 4'hf, 1'b1);
    chk(pinMaskRead, 16'h8582);
    setMask(1'b1, 16'hffff);
    chk(pinMaskRead, 16'h8582);
    setMask(1'b1, 16'h0008);
    chk(relayMaskRead, 16'h0008);
    setBit(1'b1, 4'h2, 1'b1);
    chk({relayMaskRead, pinMaskRead}, 32'h000c8582);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk); evtSel <= 4'(i); repeat (2) @(posedge clk); #1;
      chk(pinEvtEnRead, 1'((16'h8582 >> i) & 16'h0001));
    end
    $display("t_mask done");
  endtask
  task automatic t_events();
    setDir(1'b1);
    setForce(EPEM_FORCE_EVENT);
    setEvents(16'h0002);
    chk({pinOut, relayOn}, 2'h2);
    chk(pinCondMaskRead, 16'h0002);
    @(posedge clk); evtSel <= 4'h1; repeat (2) @(posedge clk); #1;
    chk(pinCondRead, 1'b1);
    setEvents(16'h8808);
    chk({pinOut, relayOn}, 2'h1);
    chk(pinCondMaskRead, 16'h0000);
    setEvents(16'h0000);
    chk({pinOut, relayOn}, 2'h0);
    $display("t_events done");
  endtask
  task automatic t_force();
    setEvents(16'h0002);
    setForce(EPEM_FORCE_LOW);
    chk({forceRead, pinOut}, 3'h0);
    setForce(EPEM_FORCE_HIGH);
    setEvents(16'h0000);
    chk({forceRead, pinOut}, 3'h3);
    chk(levelRead, 1'b1);
    setForce(2'h2);
    chk({forceRead, pinOut}, 3'h3);
    setForce(EPEM_FORCE_EVENT);
    chk({forceRead, pinOut}, 3'h6);
    $display("t_force done");
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_dir();
    t_thr();
    t_mask();
    t_events();
    t_force();
    end_sim();
  end
endmodule  // epem_monitor_bench
`default_nettype wire
